// *** shared/dlx_defs.svh ***
// Constants for the direction-load and XOR execution block
`ifndef DLX_DEFS_SVH
`define DLX_DEFS_SVH
`define DLX_OPERAND_PORT_A 3'h5
`define DLX_OPERAND_PORT_B 3'h6
`define DLX_OPERAND_PORT_C 3'h7
`define DLX_DIR_RESET 8'hff
`define DLX_ACC_RESET 8'h00
`define DLX_ZERO_RESET 1'b0
`define DLX_DEST_ACC 1'b0
`define DLX_DEST_REG 1'b1
`endif

// *** shared/dlx_pkg.sv ***
// Types for the direction-load and XOR execution block
package dlx_pkg;
  typedef enum logic [1:0] {
    DLX_OP_NONE,
    DLX_OP_DIR_LOAD,
    DLX_OP_XOR_IMM,
    DLX_OP_XOR_REG
  } dlx_op_t;

  typedef struct packed {
    dlx_op_t op;
    logic [7:0] literal;
    logic [6:0] reg_addr;
    logic [7:0] reg_data;
    logic dest;
  } dlx_instr_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } dlx_mem_wr_t;

  typedef struct packed {
    logic [7:0] acc;
    logic zero;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    dlx_mem_wr_t mem_wr;
    logic bad_operand;
  } dlx_state_t;
endpackage : dlx_pkg

// *** src/dlx_exec.sv ***
// Execution of direction-load and XOR instructions
`timescale 1ns/1ns
`include "dlx_defs.svh"

// Function
// (RULE_01) Direction load copies accumulator, operands 5-7, flags kept
// (RULE_02) Operands 5,6,7 select ports A,B,C
// (RULE_03) Immediate XOR of literal into accumulator
// (RULE_04) Immediate XOR changes only zero flag
// (RULE_05) Register XOR with 7-bit addressed register
// (RULE_06) Destination 0 accumulator, 1 register
// (RULE_07) Register XOR changes only zero flag
// (RULE_08) Zero flag set when result zero
module dlx_exec (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic instr_valid,
  input dlx_pkg::dlx_instr_t instr,
  output dlx_pkg::dlx_state_t state
);
  import dlx_pkg::*;

  dlx_state_t r;
  dlx_state_t next_r;
  logic [7:0] reg_result;
  logic [7:0] imm_result;

  assign reg_result = r.acc ^ instr.reg_data;
  assign imm_result = r.acc ^ instr.literal;
  assign state = r;

  always_comb begin
    next_r = r;
    next_r.mem_wr.valid = 1'b0;
    next_r.bad_operand = 1'b0;
    if (instr_valid) begin
      unique case (instr.op)
        DLX_OP_NONE: begin
        end
        DLX_OP_DIR_LOAD: begin
          // Flags untouched; see RULE_01
          unique case (instr.literal[2:0])
            `DLX_OPERAND_PORT_A: next_r.port_a_direction = r.acc; // see RULE_02
            `DLX_OPERAND_PORT_B: next_r.port_b_direction = r.acc; // see RULE_02
            `DLX_OPERAND_PORT_C: next_r.port_c_direction = r.acc; // see RULE_02
            default: next_r.bad_operand = 1'b1; // see RULE_01
          endcase
          if (instr.literal[7:3] != 5'h00) begin
            next_r.port_a_direction = r.port_a_direction;
            next_r.port_b_direction = r.port_b_direction;
            next_r.port_c_direction = r.port_c_direction;
            next_r.bad_operand = 1'b1; // see RULE_01
          end
        end
        DLX_OP_XOR_IMM: begin
          next_r.acc = imm_result; // see RULE_03
          next_r.zero = (imm_result == 8'h00); // see RULE_04 see RULE_08
        end
        DLX_OP_XOR_REG: begin
          next_r.zero = (reg_result == 8'h00); // see RULE_07 see RULE_08
          if (instr.dest == `DLX_DEST_ACC) begin
            next_r.acc = reg_result; // see RULE_06
          end else begin
            next_r.mem_wr.valid = 1'b1; // see RULE_05 see RULE_06
            next_r.mem_wr.addr = instr.reg_addr;
            next_r.mem_wr.data = reg_result;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r.acc <= `DLX_ACC_RESET;
      r.zero <= `DLX_ZERO_RESET;
      r.port_a_direction <= `DLX_DIR_RESET;
      r.port_b_direction <= `DLX_DIR_RESET;
      r.port_c_direction <= `DLX_DIR_RESET;
      r.mem_wr <= '0;
      r.bad_operand <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  sequence seq_imm;
    instr_valid && instr.op == DLX_OP_XOR_IMM;
  endsequence

  sequence seq_reg_acc;
    instr_valid && instr.op == DLX_OP_XOR_REG && instr.dest == `DLX_DEST_ACC;
  endsequence

  sequence seq_reg_mem;
    instr_valid && instr.op == DLX_OP_XOR_REG && instr.dest == `DLX_DEST_REG;
  endsequence

  // Direction-load and register-XOR classes
  sequence seq_dir_good;
    instr_valid && instr.op == DLX_OP_DIR_LOAD && instr.literal >= 8'h05 && instr.literal <= 8'h07;
  endsequence

  sequence seq_dir_bad;
    instr_valid && instr.op == DLX_OP_DIR_LOAD && (instr.literal < 8'h05 || instr.literal > 8'h07);
  endsequence

  sequence seq_xor_reg;
    instr_valid && instr.op == DLX_OP_XOR_REG;
  endsequence

  AST_DIR_FLAGS: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_01
    instr_valid && instr.op == DLX_OP_DIR_LOAD |=> $stable(r.zero) && $stable(r.acc))
    else $error("direction load changed flags");

  AST_DIR_A: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_02
    instr_valid && instr.op == DLX_OP_DIR_LOAD && instr.literal == 8'h05
    |=> r.port_a_direction == $past(r.acc) && $stable(r.port_b_direction) && $stable(r.port_c_direction))
    else $error("port A direction not loaded");

  AST_DIR_C: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_02
    instr_valid && instr.op == DLX_OP_DIR_LOAD && instr.literal == 8'h07
    |=> r.port_c_direction == $past(r.acc) && $stable(r.port_a_direction) && $stable(r.port_b_direction))
    else $error("port C direction not loaded");

  AST_DIR_BAD: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_01
    instr_valid && instr.op == DLX_OP_DIR_LOAD && (instr.literal < 8'h05 || instr.literal > 8'h07)
    |=> r.bad_operand && $stable(r.port_b_direction))
    else $error("bad direction operand accepted");

  AST_XOR_IMM: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_03
    seq_imm |=> r.acc == ($past(r.acc) ^ $past(instr.literal)))
    else $error("immediate xor result wrong");

  AST_ZERO_IMM: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_04
    seq_imm |=> r.zero == (r.acc == 8'h00) && $stable(r.port_a_direction))
    else $error("immediate xor zero flag wrong");

  AST_XOR_MEM: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_05
    seq_reg_mem |=> r.mem_wr.valid && r.mem_wr.addr == $past(instr.reg_addr) && $stable(r.acc)
    && r.mem_wr.data == ($past(r.acc) ^ $past(instr.reg_data)))
    else $error("register xor write back wrong");

  AST_XOR_ACC: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_06
    seq_reg_acc |=> !r.mem_wr.valid && r.acc == ($past(r.acc) ^ $past(instr.reg_data)))
    else $error("register xor to accumulator wrong");

  AST_ZERO_REG: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_07
    seq_reg_mem |=> r.zero == (r.mem_wr.data == 8'h00))
    else $error("register xor zero flag wrong");

  AST_ZERO_HOLD: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_08
    !(instr_valid && (instr.op == DLX_OP_XOR_IMM || instr.op == DLX_OP_XOR_REG)) |=> $stable(r.zero))
    else $error("zero flag changed without xor");

  AST_DIR_B: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_02
    instr_valid && instr.op == DLX_OP_DIR_LOAD && instr.literal == 8'h06
    |=> r.port_b_direction == $past(r.acc) && $stable(r.port_a_direction) && $stable(r.port_c_direction))
    else $error("port B direction not loaded");

  AST_DIR_GOOD: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_01
    seq_dir_good |=> !r.bad_operand && $stable(r.zero))
    else $error("valid direction operand refused");

  AST_DIR_BAD_KEEP: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_01
    seq_dir_bad |=> $stable(r.port_a_direction) && $stable(r.port_c_direction) && $stable(r.acc))
    else $error("bad direction operand changed state");

  AST_BAD_ONLY: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_01
    !(instr_valid && instr.op == DLX_OP_DIR_LOAD && (instr.literal < 8'h05 || instr.literal > 8'h07))
    |=> !r.bad_operand)
    else $error("bad operand flagged without cause");

  AST_DIR_HOLD: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_01
    !(instr_valid && instr.op == DLX_OP_DIR_LOAD)
    |=> $stable(r.port_a_direction) && $stable(r.port_b_direction) && $stable(r.port_c_direction))
    else $error("direction changed without direction load");

  AST_ACC_HOLD: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_06
    !(instr_valid && (instr.op == DLX_OP_XOR_IMM || (instr.op == DLX_OP_XOR_REG && instr.dest == `DLX_DEST_ACC)))
    |=> $stable(r.acc))
    else $error("accumulator changed without xor to it");

  AST_WR_ONLY: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_06
    !(instr_valid && instr.op == DLX_OP_XOR_REG && instr.dest == `DLX_DEST_REG) |=> !r.mem_wr.valid)
    else $error("register write without register xor");

  AST_ZERO_REG_ACC: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_07
    seq_reg_acc |=> r.zero == (r.acc == 8'h00) && $stable(r.port_b_direction))
    else $error("register xor to accumulator zero flag wrong");

  AST_IMM_DIRS: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_04
    seq_imm |=> !r.mem_wr.valid && $stable(r.port_b_direction) && $stable(r.port_c_direction))
    else $error("immediate xor touched other state");

  AST_REG_DIRS: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_07
    seq_xor_reg |=> $stable(r.port_a_direction) && $stable(r.port_b_direction) && $stable(r.port_c_direction))
    else $error("register xor touched directions");

  // Zero flag follows result
  AST_ZERO_IMM_VAL: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_08
    seq_imm |=> r.zero == (($past(r.acc) ^ $past(instr.literal)) == 8'h00))
    else $error("immediate xor zero value wrong");

  AST_ZERO_REG_VAL: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_08
    seq_xor_reg |=> r.zero == (($past(r.acc) ^ $past(instr.reg_data)) == 8'h00))
    else $error("register xor zero value wrong");

  AST_IMM_ZERO_SET: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_08
    instr_valid && instr.op == DLX_OP_XOR_IMM && instr.literal == r.acc |=> r.zero)
    else $error("immediate xor zero flag not set");

  AST_IMM_ZERO_CLR: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_08
    instr_valid && instr.op == DLX_OP_XOR_IMM && instr.literal != r.acc
    |=> !r.zero)
    else $error("immediate xor zero flag not cleared");

  AST_REG_ZERO_SET: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_08
    instr_valid && instr.op == DLX_OP_XOR_REG && instr.reg_data == r.acc
    |=> r.zero)
    else $error("register xor zero flag not set");

  AST_REG_ZERO_CLR: assert property (@(posedge clock) disable iff (!reset_n) // see RULE_08
    instr_valid && instr.op == DLX_OP_XOR_REG && instr.reg_data != r.acc
    |=> !r.zero)
    else $error("register xor zero flag not cleared");
endmodule : dlx_exec

// *** verif/dlx_exec_tb.sv ***
// Self-checking bench for the direction-load and XOR block
`timescale 1ns/1ns
`include "dlx_defs.svh"
module dlx_exec_tb;
  import dlx_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  dlx_instr_t instr = '0;
  dlx_state_t state;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'hcfd3_9452;
  int acc, zero, wv, wa, wd, bad, r;
  int dir [3];
  dlx_exec dlx_exec_inst (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr), .state(state));
  always #5 clock = ~clock;
  task automatic chk(input string name, input int exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp[7:0]) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp[7:0], got);
    end
  endtask : chk
  task automatic check_all;
    chk("acc", acc, state.acc);
    chk("zero", zero, {7'h00, state.zero});
    chk("port_a_direction", dir[0], state.port_a_direction);
    chk("port_b_direction", dir[1], state.port_b_direction);
    chk("port_c_direction", dir[2], state.port_c_direction);
    chk("wr_valid", wv, {7'h00, state.mem_wr.valid});
    if (wv == 1) begin
      chk("wr_addr", wa, {1'b0, state.mem_wr.addr});
      chk("wr_data", wd, state.mem_wr.data);
    end
    chk("bad_operand", bad, {7'h00, state.bad_operand});
  endtask : check_all
  // Reference behaviour of one accepted instruction
  task automatic model;
    int res;
    wv = 0;
    bad = 0;
    if (instr_valid !== 1'b1) return;
    case (instr.op)
      DLX_OP_DIR_LOAD: if (instr.literal >= 5 && instr.literal <= 7) dir[instr.literal - 5] = acc; else bad = 1;
      DLX_OP_XOR_IMM: begin
        acc = acc ^ instr.literal;
        zero = (acc == 0);
      end
      DLX_OP_XOR_REG: begin
        res = acc ^ instr.reg_data;
        zero = (res == 0);
        if (instr.dest == `DLX_DEST_REG) begin
          wv = 1;
          wa = instr.reg_addr;
          wd = res;
        end else acc = res;
      end
      default: ;
    endcase
  endtask : model
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #10000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (2) begin
      reset_n = 1'b0;
      instr_valid = 1'b0;
      acc = `DLX_ACC_RESET;
      zero = `DLX_ZERO_RESET;
      dir = '{`DLX_DIR_RESET, `DLX_DIR_RESET, `DLX_DIR_RESET};
      wv = 0;
      bad = 0;
      @(negedge clock);
      check_all();
      repeat (4) @(negedge clock);
      reset_n = 1'b1;
      repeat (300) begin
        @(negedge clock);
        check_all();
        r = $random(seed);
        instr_valid = r[0] | r[1];
        instr.op = dlx_op_t'(r[3:2]);
        instr.literal = r[4] ? {5'h00, r[10:8]} : (r[5] ? acc[7:0] : r[15:8]);
        instr.reg_addr = r[22:16];
        instr.reg_data = r[7] ? acc[7:0] : r[31:24];
        instr.dest = r[6];
        model();
      end
      @(negedge clock);
      check_all();
    end
    report_and_stop();
  end
endmodule : dlx_exec_tb
